//--- pkg/mdc_pkg.sv
// Purpose: constants and types of the mixed decay chopping sequencer
// Assumes: 20 MHz mclk_i; comparator and tick inputs synchronous to it
// Notes: times are kept in ns and converted to cycles once here
// Operation
// - charge, fast decay, slow decay in turn; only slow decay ends at period end
// - chop period is sixteen oscillator ticks
// - period end in slow decay starts charge until peak trip
// - peak trip moves bridge to fast decay
// - decay trip holds slow decay until period end
// - 400 ns all-off dead time per change
// - ignore peak comparator 1.25 us after charge
// - reject peak pulses shorter than 0.35 us
// - ignore decay comparator 2.2 us after fast decay starts
// - reject decay pulses shorter than 0.35 us
// - overcurrent turns all off until standby
package mdc_pkg;

    localparam int CLK_MHZ = 20;

    // times in ns as specified
    localparam int DEAD_NS = 400;
    localparam int PEAK_BLANK_NS = 1250;
    localparam int DECAY_BLANK_NS = 2200;
    localparam int FILT_NS = 350;

    // least times round up to whole cycles
    localparam int NS_PER_US = 1000;
    localparam int DEAD_CYC_I = (DEAD_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int PEAK_BLANK_CYC_I = (PEAK_BLANK_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int DECAY_BLANK_CYC_I = (DECAY_BLANK_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int FILT_CYC_I = (FILT_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;

    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
    localparam logic [CNT_W-1:0] DEAD_CYC = CNT_W'(DEAD_CYC_I);
    localparam logic [CNT_W-1:0] PEAK_BLANK_CYC = CNT_W'(PEAK_BLANK_CYC_I);
    localparam logic [CNT_W-1:0] DECAY_BLANK_CYC = CNT_W'(DECAY_BLANK_CYC_I);

    localparam int FILT_W = 4;
    localparam logic [FILT_W-1:0] FILT_CYC = FILT_W'(FILT_CYC_I);
    localparam logic [FILT_W-1:0] FILT_ZERO = 4'h0;

    // chop period: ticks 0..15
    localparam int TICK_W = 4;
    localparam logic [TICK_W-1:0] TICK_ZERO = 4'h0;
    localparam logic [TICK_W-1:0] TICK_LAST = 4'hF;

    // gate vector order {hs_a, ls_a, hs_b, ls_b}
    localparam logic [3:0] GATES_OFF = 4'h0;
    localparam logic [3:0] GATES_CHG_FWD = 4'h9;
    localparam logic [3:0] GATES_CHG_REV = 4'h6;
    localparam logic [3:0] GATES_SLOW = 4'h5;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DEAD = 3'h1,
        ST_CHARGE = 3'h2,
        ST_FAST = 3'h3,
        ST_SLOW = 3'h4,
        ST_SHUT = 3'h5
    } mdc_state_e;

endpackage

//--- src/mdc_pulse_filter.sv
// Purpose: reject comparator pulses shorter than the filter time
// Assumes: level_i synchronous to mclk_i
// Notes: output rises only after level_i held high FILT_CYC cycles
`timescale 1ns/1ps
`default_nettype none
module mdc_pulse_filter
    import mdc_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // comparator level
    input wire logic level_i,
    output logic level_o
);

    logic [FILT_W-1:0] run_ff;
    logic [FILT_W-1:0] nxt_run;
    logic out_ff;
    logic held_long;

    assign held_long = (run_ff >= FILT_CYC);
    // saturate so a long level never wraps back to low
    assign nxt_run = !level_i ? FILT_ZERO : (held_long ? run_ff : run_ff + 4'h1);

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            run_ff <= FILT_ZERO;
            out_ff <= 1'b0;
        end else begin
            run_ff <= nxt_run;
            out_ff <= level_i && (nxt_run >= FILT_CYC);
        end
    end

    assign level_o = out_ff;

endmodule // mdc_pulse_filter
`default_nettype wire

//--- src/mdc_chopper.sv
// Purpose: constant-current chop sequencer for one bridge winding
// Assumes: all inputs synchronous to mclk_i; osc_tick_i one-cycle pulses
// Notes: gate commands and status leave straight from flip-flops
`timescale 1ns/1ps
`default_nettype none
module mdc_chopper
    import mdc_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // chop oscillator
    input wire logic osc_tick_i,
    // bridge comparators
    input wire logic peak_cmp_i,
    input wire logic decay_cmp_i,
    input wire logic overcurrent_i,
    // control
    input wire logic standby_i,
    input wire logic dir_i,
    // gate commands
    output logic gate_hs_a_o,
    output logic gate_ls_a_o,
    output logic gate_hs_b_o,
    output logic gate_ls_b_o,
    // status
    output logic [2:0] phase_o,
    output logic shutdown_o,
    output logic period_start_o
);

    // gate pattern for a settled phase and current direction
    function automatic logic [3:0] phase_gates(input mdc_state_e st, input logic fwd);
        logic [3:0] chg;
        chg = fwd ? GATES_CHG_FWD : GATES_CHG_REV;
        case (st)
            ST_CHARGE: phase_gates = chg;
            ST_FAST: phase_gates = ~chg;
            ST_SLOW: phase_gates = GATES_SLOW;
            default: phase_gates = GATES_OFF;
        endcase
    endfunction

    // count-down step that stops at zero
    function automatic logic [CNT_W-1:0] dec_sat(input logic [CNT_W-1:0] v);
        dec_sat = (v == CNT_ZERO) ? CNT_ZERO : v - 6'h01;
    endfunction

    mdc_state_e state_ff;
    mdc_state_e nxt_state;
    mdc_state_e tgt_ff;
    mdc_state_e nxt_tgt;
    logic [TICK_W-1:0] tick_ff;
    logic [TICK_W-1:0] nxt_tick;
    logic [CNT_W-1:0] dead_ff;
    logic [CNT_W-1:0] nxt_dead;
    logic [CNT_W-1:0] blank_ff;
    logic [CNT_W-1:0] nxt_blank;
    logic pend_ff;
    logic nxt_pend;
    logic dir_ff;
    logic nxt_dir;
    logic [3:0] gates_ff;
    logic [3:0] nxt_gates;
    logic period_ff;
    logic shut_ff;

    logic peak_filt;
    logic decay_filt;
    logic period_end;
    logic blank_done;
    logic dead_done;
    logic peak_hit;
    logic decay_hit;
    logic slow_over;
    logic go_dead;
    logic entering;

    // short pulses on either comparator are rejected here
    mdc_pulse_filter u_peak_filt (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .level_i(peak_cmp_i),
        .level_o(peak_filt)
    );

    mdc_pulse_filter u_decay_filt (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .level_i(decay_cmp_i),
        .level_o(decay_filt)
    );

    // period counter runs only while the bridge is live
    assign period_end = osc_tick_i && (tick_ff == TICK_LAST);
    assign nxt_tick = (standby_i || state_ff == ST_SHUT) ? TICK_ZERO :
                      (osc_tick_i ? tick_ff + 4'h1 : tick_ff);

    assign blank_done = (blank_ff == CNT_ZERO);
    assign dead_done = (dead_ff == CNT_ZERO);
    assign peak_hit = (state_ff == ST_CHARGE) && blank_done && peak_filt;
    assign decay_hit = (state_ff == ST_FAST) && blank_done && decay_filt;
    assign slow_over = (state_ff == ST_SLOW) && (period_end || pend_ff);

    // period boundary seen while settling into slow decay must not be lost
    // standby or shutdown drops it, so no old boundary can cut a later slow phase
    assign nxt_pend = (period_end || pend_ff) && !standby_i && !overcurrent_i &&
                      (state_ff == ST_DEAD) && (tgt_ff == ST_SLOW);

    // phase sequencing
    always_comb begin
        nxt_state = state_ff;
        nxt_tgt = tgt_ff;
        go_dead = 1'b0;
        if (standby_i) begin
            nxt_state = ST_IDLE;
            nxt_tgt = ST_IDLE;
        end else if (overcurrent_i || state_ff == ST_SHUT) begin
            nxt_state = ST_SHUT;
            nxt_tgt = ST_SHUT;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (period_end) begin
                        go_dead = 1'b1;
                        nxt_tgt = ST_CHARGE;
                    end
                end
                ST_DEAD: begin
                    if (dead_done) begin
                        nxt_state = tgt_ff;
                    end
                end
                ST_CHARGE: begin
                    // no trip: charge simply carries over the boundary
                    if (peak_hit) begin
                        go_dead = 1'b1;
                        nxt_tgt = ST_FAST;
                    end
                end
                ST_FAST: begin
                    // no trip: fast decay carries over the boundary
                    if (decay_hit) begin
                        go_dead = 1'b1;
                        nxt_tgt = ST_SLOW;
                    end
                end
                ST_SLOW: begin
                    if (slow_over) begin
                        go_dead = 1'b1;
                        nxt_tgt = ST_CHARGE;
                    end
                end
                default: begin
                    nxt_state = ST_IDLE;
                    nxt_tgt = ST_IDLE;
                end
            endcase
            if (go_dead) begin
                nxt_state = ST_DEAD;
            end
        end
    end

    // every switching change passes through an all-off interval
    assign nxt_dead = go_dead ? DEAD_CYC - 6'h01 : dec_sat(dead_ff);

    // blanking windows start as the new phase begins conducting
    assign entering = (state_ff == ST_DEAD) && dead_done;
    assign nxt_blank = (entering && tgt_ff == ST_CHARGE) ? PEAK_BLANK_CYC - 6'h01 :
                       (entering && tgt_ff == ST_FAST) ? DECAY_BLANK_CYC - 6'h01 :
                       dec_sat(blank_ff);

    // direction is only changed at a charge start, never mid-phase
    assign nxt_dir = (entering && tgt_ff == ST_CHARGE) ? dir_i : dir_ff;

    assign nxt_gates = phase_gates(nxt_state, nxt_dir);

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff <= ST_IDLE;
            tgt_ff <= ST_IDLE;
            tick_ff <= TICK_ZERO;
            dead_ff <= CNT_ZERO;
            blank_ff <= CNT_ZERO;
            pend_ff <= 1'b0;
            dir_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            tgt_ff <= nxt_tgt;
            tick_ff <= nxt_tick;
            dead_ff <= nxt_dead;
            blank_ff <= nxt_blank;
            pend_ff <= nxt_pend;
            dir_ff <= nxt_dir;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gates_ff <= GATES_OFF;
            period_ff <= 1'b0;
            shut_ff <= 1'b0;
        end else begin
            gates_ff <= nxt_gates;
            period_ff <= period_end && !standby_i;
            shut_ff <= (nxt_state == ST_SHUT);
        end
    end

    assign gate_hs_a_o = gates_ff[3];
    assign gate_ls_a_o = gates_ff[2];
    assign gate_hs_b_o = gates_ff[1];
    assign gate_ls_b_o = gates_ff[0];
    assign phase_o = state_ff;
    assign shutdown_o = shut_ff;
    assign period_start_o = period_ff;

endmodule // mdc_chopper
`default_nettype wire

//--- verif/mdc_chopper_props.sv
// Purpose: port checks of the chop sequencer
// Assumes: one clock, reset active low
// Notes: helper counters age each phase and time comparator high runs
`timescale 1ns/1ps
`default_nettype none
module mdc_chopper_props
    import mdc_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // inputs
    input wire logic osc_tick_i,
    input wire logic peak_cmp_i,
    input wire logic decay_cmp_i,
    input wire logic overcurrent_i,
    input wire logic standby_i,
    // outputs
    input wire logic gate_hs_a_o,
    input wire logic gate_ls_a_o,
    input wire logic gate_hs_b_o,
    input wire logic gate_ls_b_o,
    input wire logic [2:0] phase_o,
    input wire logic shutdown_o,
    input wire logic period_start_o
);
    logic [5:0] age_ff;
    logic [3:0] run_ff;
    logic [3:0] dc_run_ff;
    logic [2:0] ph_ff;
    logic [2:0] last_ff;
    wire off = !(gate_hs_a_o | gate_ls_a_o | gate_hs_b_o | gate_ls_b_o);
    wire [2:0] exp_ph = (last_ff == 3'h2) ? 3'h3 : (last_ff == 3'h3) ? 3'h4 : 3'h2;
    wire leave_chg = ph_ff == 3'h2 && phase_o == 3'h1;
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            age_ff <= 6'h00;
            run_ff <= 4'h0;
            dc_run_ff <= 4'h0;
            ph_ff <= 3'h0;
            last_ff <= 3'h0;
        end else begin
            // saturate so long phases stay comparable
            age_ff <= (phase_o != ph_ff) ? 6'h00 : age_ff + {5'h00, age_ff != 6'h3F};
            run_ff <= peak_cmp_i ? run_ff + {3'h0, run_ff != 4'hF} : 4'h0;
            dc_run_ff <= decay_cmp_i ? dc_run_ff + {3'h0, dc_run_ff != 4'hF} : 4'h0;
            ph_ff <= phase_o;
            last_ff <= (phase_o == 3'h1) ? last_ff : phase_o;
        end
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);
    sequence s_dead8;
        (phase_o == 3'h1)[*8];
    endsequence
    property p_dead_len;
        phase_o == 3'h1 && ph_ff != 3'h1 |-> s_dead8 ##1 phase_o != 3'h1;
    endproperty
    a_dead_len: assert property (p_dead_len) else $error("dead length");
    property p_dead_off;
        phase_o == 3'h1 || phase_o == 3'h5 |-> off;
    endproperty
    a_dead_off: assert property (p_dead_off) else $error("gates on");
    property p_order;
        ph_ff == 3'h1 && phase_o inside {3'h2, 3'h3, 3'h4} |-> phase_o == exp_ph;
    endproperty
    a_order: assert property (p_order) else $error("phase order");
    property p_pk_blank;
        leave_chg |-> age_ff >= 6'h18;
    endproperty
    a_pk_blank: assert property (p_pk_blank) else $error("peak blank");
    property p_pk_filt;
        leave_chg |-> $past(run_ff, 2) >= 4'h6;
    endproperty
    a_pk_filt: assert property (p_pk_filt) else $error("peak filter");
    property p_dc_blank;
        ph_ff == 3'h3 && phase_o == 3'h1 |-> age_ff >= 6'h2B;
    endproperty
    a_dc_blank: assert property (p_dc_blank) else $error("decay blank");
    // leaving fast decay needs a long enough decay level, never the period end alone
    property p_dc_filt;
        ph_ff == 3'h3 && phase_o == 3'h1 |-> $past(dc_run_ff, 2) >= 4'h6;
    endproperty
    a_dc_filt: assert property (p_dc_filt) else $error("decay filter");
    property p_shut;
        overcurrent_i && !standby_i |=> phase_o == 3'h5 && shutdown_o;
    endproperty
    a_shut: assert property (p_shut) else $error("no shutdown");
    property p_shut_hold;
        shutdown_o && !standby_i |=> shutdown_o;
    endproperty
    a_shut_hold: assert property (p_shut_hold) else $error("shutdown lost");
    property p_period;
        period_start_o |-> $past(osc_tick_i);
    endproperty
    a_period: assert property (p_period) else $error("period start");
endmodule // mdc_chopper_props
`default_nettype wire

//--- verif/mdc_bridge_model.sv
// Purpose: bridge stage with current comparators
// Assumes: gate vector {hs_a, ls_a, hs_b, ls_b}
// Notes: slow decay holds current, the hardest case
`timescale 1ns/1ps
`default_nettype none
module mdc_bridge_model (
    // clock and gates
    input wire logic mclk_i,
    input wire logic [3:0] gates_i,
    // test controls
    input wire logic slow_i,
    input wire logic noise_i,
    // comparators
    output logic peak_cmp_o,
    output logic decay_cmp_o
);
    localparam int PEAK = 200;
    localparam int DECAY = 100;
    int cur = 0;
    int mag;
    int step;
    assign step = slow_i ? 1 : 4;
    always @(posedge mclk_i) begin
        if (gates_i == 4'h9) begin
            cur <= cur + step;
        end else if (gates_i == 4'h6) begin
            cur <= cur - step;
        end
    end
    assign mag = (cur < 0) ? -cur : cur;
    assign peak_cmp_o = (mag >= PEAK) || noise_i;
    assign decay_cmp_o = mag <= DECAY;
endmodule // mdc_bridge_model
`default_nettype wire

//--- verif/mdc_chopper_tb.sv
// Purpose: self-checking bench of the chop sequencer
// Assumes: inputs change at falling edges
// Notes: gates modelled from phase every cycle
`timescale 1ns/1ps
`default_nettype none
module mdc_chopper_tb
    import mdc_pkg::*;
;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic osc_tick_i = 1'b0;
    logic overcurrent_i = 1'b0;
    logic standby_i = 1'b0;
    logic dir_i = 1'b1;
    logic slow = 1'b1;
    logic noise = 1'b0;
    logic tick_en = 1'b1;
    logic dq = 1'b1;
    logic exp_ps = 1'b0;
    wire peak_cmp_i, decay_cmp_i, shutdown_o, period_start_o;
    wire [3:0] gates;
    wire [2:0] phase_o;
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int tcnt = 0;
    int gap = 0;
    mdc_chopper u_dut (.mclk_i, .rstn_i, .osc_tick_i, .peak_cmp_i, .decay_cmp_i,
        .overcurrent_i, .standby_i, .dir_i, .gate_hs_a_o(gates[3]), .gate_ls_a_o(gates[2]),
        .gate_hs_b_o(gates[1]), .gate_ls_b_o(gates[0]), .phase_o, .shutdown_o, .period_start_o);
    mdc_bridge_model u_bridge (.mclk_i, .gates_i(gates), .slow_i(slow), .noise_i(noise),
        .peak_cmp_o(peak_cmp_i), .decay_cmp_o(decay_cmp_i));
    always #25 mclk_i = ~mclk_i;
    function automatic logic [3:0] exp_g(input logic [2:0] p, input logic d);
        case (p)
            3'h2: exp_g = d ? GATES_CHG_FWD : GATES_CHG_REV;
            3'h3: exp_g = d ? GATES_CHG_REV : GATES_CHG_FWD;
            3'h4: exp_g = GATES_SLOW;
            default: exp_g = GATES_OFF;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wait_ph(input logic [2:0] p);
        int i = 0;
        while (phase_o !== p && i < 3000) begin
            @(negedge mclk_i);
            i++;
        end
        chk("phase", {1'b0, p}, {1'b0, phase_o});
    endtask
    task automatic test_done();
        if (n_errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(negedge mclk_i) begin
        if (gap == 0) begin
            osc_tick_i <= tick_en;
            gap <= 2 + $urandom % 4;
        end else begin
            osc_tick_i <= 1'b0;
            gap <= gap - 1;
        end
        if (rstn_i) begin
            // direction is taken as the dead time ends
            if (phase_o === 3'h1) dq = dir_i;
            chk("gates", exp_g(phase_o, dq), gates);
            chk("start", {3'h0, exp_ps}, {3'h0, period_start_o});
        end
    end
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc > 20000) begin
            n_errors++;
            test_done();
        end else begin
            exp_ps <= 1'b0;
            if (!rstn_i || standby_i || shutdown_o) begin
                tcnt <= 0;
            end else if (osc_tick_i) begin
                tcnt <= (tcnt + 1) % 16;
                exp_ps <= (tcnt == 15);
            end
        end
    end
    initial begin
        void'($urandom(99));
        repeat (2) @(negedge mclk_i);
        rstn_i = 1'b1;
        chk("phase", 4'h0, {1'b0, phase_o});
        wait_ph(3'h2);
        repeat (30) @(negedge mclk_i);
        noise = 1'b1;
        repeat (5) @(negedge mclk_i);
        noise = 1'b0;
        repeat (8) @(negedge mclk_i);
        chk("phase", 4'h2, {1'b0, phase_o});
        wait_ph(3'h3);
        wait_ph(3'h4);
        slow = 1'b0;
        dir_i = 1'($urandom % 2);
        wait_ph(3'h2);
        wait_ph(3'h3);
        wait_ph(3'h4);
        wait_ph(3'h2);
        tick_en = 1'b0;
        repeat (10) @(negedge mclk_i);
        overcurrent_i = 1'b1;
        @(negedge mclk_i);
        overcurrent_i = 1'b0;
        repeat (20) @(negedge mclk_i);
        chk("shut", 4'hD, {shutdown_o, phase_o});
        standby_i = 1'b1;
        repeat (3) @(negedge mclk_i);
        chk("shut", 4'h0, {shutdown_o, phase_o});
        standby_i = 1'b0;
        tick_en = 1'b1;
        // opposite direction, so both charge patterns meet the gate compare
        dir_i = ~dir_i;
        wait_ph(3'h2);
        repeat (2) @(negedge mclk_i);
        test_done();
    end
endmodule // mdc_chopper_tb
bind mdc_chopper mdc_chopper_props u_props (.mclk_i, .rstn_i, .osc_tick_i, .peak_cmp_i,
    .decay_cmp_i, .overcurrent_i, .standby_i, .gate_hs_a_o, .gate_ls_a_o, .gate_hs_b_o,
    .gate_ls_b_o,
    .phase_o, .shutdown_o, .period_start_o);
`default_nettype wire
